// >>> tb/dio_field.sv
// field switch model: six terminal contacts with optional contact bounce
`timescale 1ns/10ps
module dio_field (
	input  wire logic       ref_clk,
	input  wire logic [5:0] level,
	input  wire logic       bounce,
	output logic [5:0]      terminal_pin
);
	logic [2:0] ph = 3'h0;
	always @(posedge ref_clk) begin
		ph <= ph + 3'h1;
	end
	// a chattering contact flips for one cycle in eight, shorter than any filter above zero
	assign terminal_pin = (bounce && ph == 3'h0) ? ~level : level;
endmodule // dio_field

// >>> tb/dio_top_props.sv
// concurrent checks on the ports of the digital i/o conditioning block
`timescale 1ns/10ps
module dio_top_props #(
	parameter int N_IN        = 6,
	parameter int N_OUT       = 4,
	parameter int TICK_CYCLES = 4
) (
	input wire logic                 ref_clk,
	input wire logic                 srst,
	input wire logic                 clk_en,
	input wire logic [N_IN-1:0]      terminal_pin,
	input wire dio_pkg::dio_drive_s  drive,
	input wire logic [7:0]           reg_addr,
	input wire logic [15:0]          reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [15:0]          reg_rdata,
	input wire logic [N_IN-1:0]      cond_in,
	input wire dio_pkg::dio_wiring_e wiring_mode,
	input wire logic                 fire_mode_trigger,
	input wire logic                 tension_pid_switch,
	input wire dio_pkg::dio_dout_s   dout,
	input wire logic                 pulse_mode_sel
);
	import dio_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not idle");
	pol_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata[15:6] == 10'h000)
		else $error("polarity read too wide");
	snap_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h1C |-> reg_rdata[15:6] == 10'h000)
		else $error("snapshot read too wide");
	live_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h1D |-> reg_rdata == {10'h000, $past(cond_in, 2)})
		else $error("live state read wrong");
	rst_clear_a: assert property ($fell(srst) |-> cond_in == 6'h00 && dout == 4'h0 && !fire_mode_trigger)
		else $error("outputs not clear after reset");
	fire_cond_a: assert property (fire_mode_trigger |-> $past(cond_in) != 6'h00)
		else $error("fire trigger without active input");
	tension_cond_a: assert property (tension_pid_switch |-> $past(cond_in) != 6'h00)
		else $error("tension switch without active input");
	pulse_force_a: assert property (pulse_mode_sel && $past(pulse_mode_sel) |-> !dout.pulse_capable_output)
		else $error("pulse output driven in pulse mode");
	wiring_set_a: assert property (reg_wr && reg_addr == 8'h04 ##1 !reg_wr |-> ##1 wiring_mode == $past(reg_wdata[1:0], 2))
		else $error("wiring mode not taken");
endmodule // dio_top_props

bind dio_top dio_top_props #(.N_IN(N_IN), .N_OUT(N_OUT), .TICK_CYCLES(TICK_CYCLES)) dio_top_props_i (.ref_clk, .srst,
	.clk_en, .terminal_pin, .drive, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cond_in, .wiring_mode,
	.fire_mode_trigger, .tension_pid_switch, .dout, .pulse_mode_sel);

// >>> tb/dio_top_tb_top.sv
// self-checking bench of the digital i/o conditioning block
`timescale 1ns/10ps
module dio_top_tb_top;
	import dio_pkg::*;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic        clk_en = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [5:0]  level = 6'h00;
	logic        bounce = 1'b0;
	logic        look = 1'b0;
	logic        rd_d = 1'b0;
	dio_drive_s  drive = '0;
	logic [5:0]  terminal_pin;
	logic [15:0] reg_rdata;
	logic [5:0]  cond_in;
	dio_wiring_e wiring_mode;
	logic        fire_mode_trigger;
	logic        tension_pid_switch;
	dio_dout_s   dout;
	logic        pulse_mode_sel;
	logic [15:0] pv;
	logic [31:0] t;
	logic [15:0] rq[$];
	logic [31:0] oq[$];
	int          fail_count = 0;
	int          comparisons = 0;
	int          seed = 27398;
	int          i;
	int          c;
	int          r;
	logic [7:0]  ra[7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h1C, 8'h1D, 8'h3F};
	logic [15:0] rv[7] = '{16'h0000, 16'h000A, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

	initial forever #25 ref_clk = ~ref_clk;

	dio_field dio_field_i (.ref_clk, .level, .bounce, .terminal_pin);
	dio_top #(.TICK_CYCLES(4)) dio_top_i (.ref_clk, .srst, .clk_en, .terminal_pin, .drive, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cond_in, .wiring_mode, .fire_mode_trigger,
		.tension_pid_switch, .dout, .pulse_mode_sel);

	assign pv = {fire_mode_trigger, tension_pid_switch, pulse_mode_sel, 1'b0, dout, wiring_mode, cond_in};

	task automatic give_verdict;
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask

	// each access takes two cycles so a strobe is never lowered and raised in one step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		rq.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic ck(input logic [15:0] m, input logic [15:0] e);
		oq.push_back({m, e});
		look <= 1'b1;
		@(posedge ref_clk);
		look <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wait_in(input int n, input logic v);
		for (r = 0; r < 40 && cond_in[n] !== v; r++)
			@(posedge ref_clk);
		if (r == 40) begin
			fail_count++;
			$display("[FAIL] cond_in wait expected %b seen %b", v, cond_in[n]);
			give_verdict;
		end
	endtask

	function automatic logic fn_out(input int k);
		case (k)
			1: return drive.running & ~drive.out_freq_zero;
			2: return drive.forward & ~drive.out_freq_zero;
			3: return drive.reverse & ~drive.out_freq_zero;
			4: return drive.jogging & ~drive.out_freq_zero;
			5: return drive.fault;
			6: return drive.freq_level_detect_one;
			7: return drive.freq_level_detect_two;
			8: return drive.freq_reached;
			9: return drive.out_freq_zero & drive.ref_freq_zero;
			10: return drive.running & drive.at_upper_limit;
			11: return drive.running & drive.at_lower_limit;
			12: return drive.main_power_ok & drive.ctrl_power_ok & ~drive.protection_active & drive.ready_to_run;
			default: return 1'b0;
		endcase
	endfunction

	always @(posedge ref_clk) begin
		if (rd_d)
			chk("reg_rdata", rq.pop_front(), reg_rdata);
		if (look) begin
			t = oq.pop_front();
			chk("ports", t[15:0], pv & t[31:16]);
		end
		rd_d <= reg_rd;
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		fail_count++;
		give_verdict;
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		for (i = 0; i < 7; i++)
			rd(ra[i], rv[i]);
		wr(8'h00, 16'hFFFF);
		rd(8'h00, 16'h003F);
		wr(8'h01, 16'hFFFF);
		rd(8'h01, 16'h03E8);
		wr(8'h10, 16'hFFFF);
		rd(8'h10, 16'hC350);
		wr(8'h1D, 16'h0001);
		rd(8'h1D, 16'h0000);
		wr(8'h00, 16'h0000);
		wr(8'h01, 16'h0000);
		wr(8'h10, 16'h0000);
		// a write while the clock enable is low must not land
		clk_en <= 1'b0;
		wr(8'h00, 16'h003F);
		clk_en <= 1'b1;
		rd(8'h00, 16'h0000);
		for (i = 0; i < 4; i++) begin
			wr(8'h04, 16'(i));
			ck(16'h00C0, 16'(i) << 6);
		end
		wr(8'h02, 16'h0031);
		wr(8'h03, 16'h0021);
		repeat (6) @(posedge ref_clk);
		ck(16'h003F, 16'h0021);
		wr(8'h00, 16'h0012);
		repeat (6) @(posedge ref_clk);
		ck(16'h003F, 16'h0033);
		rd(8'h1D, 16'h0033);
		wr(8'h0A, 16'h0052);
		wr(8'h0F, 16'h0053);
		wr(8'h0B, 16'h0054);
		ck(16'hC000, 16'hC000);
		wr(8'h0A, 16'h0054);
		ck(16'hC000, 16'h4000);
		drive <= 16'h0800;
		repeat (3) @(posedge ref_clk);
		wr(8'h00, 16'h0000);
		repeat (6) @(posedge ref_clk);
		rd(8'h1C, 16'h0033);
		drive <= '0;
		wr(8'h02, 16'h0000);
		wr(8'h0F, 16'h0000);
		// filter of 2 ms rejects chatter on a contact held open
		wr(8'h01, 16'h0002);
		bounce <= 1'b1;
		repeat (40) @(posedge ref_clk);
		ck(16'h003F, 16'h0000);
		bounce <= 1'b0;
		level[4] <= 1'b1;
		repeat (6) @(posedge ref_clk);
		ck(16'h0010, 16'h0000);
		wait_in(4, 1'b1);
		level[4] <= 1'b0;
		wait_in(4, 1'b0);
		wr(8'h01, 16'h0000);
		for (i = 0; i < 6; i++) begin
			wr(8'h10 + 8'(2 * i), 16'h0003);
			wr(8'h11 + 8'(2 * i), 16'h0002);
			level[i] <= 1'b1;
			repeat (12) @(posedge ref_clk);
			ck(16'h003F, 16'h0000);
			wait_in(i, 1'b1);
			ck(16'h003F, 16'h0001 << i);
			level[i] <= 1'b0;
			repeat (5) @(posedge ref_clk);
			ck(16'h003F, 16'h0001 << i);
			wait_in(i, 1'b0);
		end
		for (c = 0; c < 13; c++) begin
			wr(8'h06, 16'(c));
			wr(8'h07, 16'(c));
			wr(8'h08, 16'(12 - c));
			wr(8'h09, 16'((c + 5) % 13));
			for (i = 0; i < 4; i++) begin
				drive <= 16'($random(seed));
				@(posedge ref_clk);
				ck(16'h0F00, {4'h0, fn_out(c), fn_out(c), fn_out(12 - c), fn_out((c + 5) % 13), 8'h00});
			end
		end
		wr(8'h05, 16'h0001);
		wr(8'h09, 16'h0005);
		drive <= 16'h0800;
		repeat (2) @(posedge ref_clk);
		ck(16'h2100, 16'h2000);
		wr(8'h05, 16'h0000);
		ck(16'h2100, 16'h0100);
		give_verdict;
	end
endmodule // dio_top_tb_top

// >>> verilog/dio_cfg.svh
// register offsets, reset values, field limits and timing counts of the digital i/o conditioning block
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH

`define DIO_ADDR_POLARITY    8'h00
`define DIO_ADDR_FILTER      8'h01
`define DIO_ADDR_VIRT_EN     8'h02
`define DIO_ADDR_VIRT_VAL    8'h03
`define DIO_ADDR_WIRING      8'h04
`define DIO_ADDR_PULSE_MODE  8'h05
`define DIO_ADDR_OUT_FUNC0   8'h06
`define DIO_ADDR_IN_FUNC0    8'h0A
`define DIO_ADDR_DELAY0      8'h10
`define DIO_ADDR_FAULT_SNAP  8'h1C
`define DIO_ADDR_LIVE_STATE  8'h1D

`define DIO_RST_POLARITY     6'h00
`define DIO_RST_FILTER_MS    10'h00A
`define DIO_RST_VIRT_EN      6'h00
`define DIO_RST_WIRING       2'h0
`define DIO_RST_DELAY_MS     16'h0000
`define DIO_RST_FAULT_SNAP   16'h0000
`define DIO_RST_LIVE_STATE   8'h00

`define DIO_MAX_FILTER_MS    10'h3E8
`define DIO_MAX_DELAY_MS     16'hC350

`define DIO_IN_FIRE_MODE     7'h52
`define DIO_IN_TENSION_PID   7'h53

`define DIO_OUT_NONE         6'h00
`define DIO_OUT_RUNNING      6'h01
`define DIO_OUT_FORWARD      6'h02
`define DIO_OUT_REVERSE      6'h03
`define DIO_OUT_JOG          6'h04
`define DIO_OUT_FAULT        6'h05
`define DIO_OUT_FREQ_LEVEL_ONE 6'h06
`define DIO_OUT_FREQ_LEVEL_TWO 6'h07
`define DIO_OUT_FREQ_REACHED 6'h08
`define DIO_OUT_ZERO_SPEED   6'h09
`define DIO_OUT_UPPER_LIMIT  6'h0A
`define DIO_OUT_LOWER_LIMIT  6'h0B
`define DIO_OUT_READY        6'h0C

`define DIO_CLK_HZ           20000000
`define DIO_TICK_US          1000
`define DIO_TICK_CYCLES      ((`DIO_CLK_HZ / 1000000) * `DIO_TICK_US)

`endif

// >>> verilog/dio_pkg.sv
// types shared by the digital i/o conditioning block
package dio_pkg;

	typedef enum logic [1:0] {
		DIO_TWO_WIRE_ONE,
		DIO_TWO_WIRE_TWO,
		DIO_THREE_WIRE_ONE,
		DIO_THREE_WIRE_TWO
	} dio_wiring_e;

	typedef struct packed {
		logic running;
		logic forward;
		logic reverse;
		logic jogging;
		logic fault;
		logic freq_level_detect_one;
		logic freq_level_detect_two;
		logic freq_reached;
		logic out_freq_zero;
		logic ref_freq_zero;
		logic at_upper_limit;
		logic at_lower_limit;
		logic main_power_ok;
		logic ctrl_power_ok;
		logic protection_active;
		logic ready_to_run;
	} dio_drive_s;

	typedef struct packed {
		logic relay_one;
		logic relay_two;
		logic open_collector;
		logic pulse_capable_output;
	} dio_dout_s;

	typedef logic [5:0] dio_func_t;

endpackage

// >>> verilog/dio_term.sv
// one input terminal: debounce filter followed by switch-on and switch-off delays
`timescale 1ns/10ps
`include "dio_cfg.svh"

module dio_term #(
	parameter int FW = 10,
	parameter int DW = 16
) (
	input  wire logic          ref_clk,
	input  wire logic          srst,
	input  wire logic          clk_en,
	input  wire logic          ms_tick,
	input  wire logic          raw,
	input  wire logic [FW-1:0] filt_ms,
	input  wire logic [DW-1:0] on_ms,
	input  wire logic [DW-1:0] off_ms,
	output logic               cond
);
	logic          deb;
	logic [FW-1:0] deb_cnt;
	logic [DW-1:0] dly_cnt;
	logic [DW-1:0] target;

	assign target = deb ? on_ms : off_ms;

	// debounce: raw must stay different for filt_ms ticks; phase of the tick gives up to 1 ms extra
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			deb     <= 1'b0;
			deb_cnt <= '0;
		end else if (clk_en) begin
			if (raw == deb) begin
				deb_cnt <= '0;
			end else if (filt_ms == '0) begin
				deb <= raw;
			end else if (ms_tick) begin
				if (deb_cnt >= filt_ms) begin
					deb     <= raw;
					deb_cnt <= '0;
				end else begin
					deb_cnt <= deb_cnt + FW'(1);
				end
			end
		end
	end

	// separate on and off delays; a bounce back cancels the pending change
	// the partial first tick is not trusted, so one tick more than the setting is counted
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cond    <= 1'b0;
			dly_cnt <= '0;
		end else if (clk_en) begin
			if (deb == cond) begin
				dly_cnt <= '0;
			end else if (target == '0) begin
				cond <= deb;
			end else if (ms_tick) begin
				if (dly_cnt >= target) begin
					cond    <= deb;
					dly_cnt <= '0;
				end else begin
					dly_cnt <= dly_cnt + DW'(1);
				end
			end
		end
	end

endmodule // dio_term

// >>> verilog/dio_top.sv
// digital i/o terminal conditioning: input filtering and delays, output function selection, registers
//
// Contract
// - input function 82 triggers fire mode, 83 switches tension pid; 84-95 ignored
// - six-bit input polarity mask, reset 0x00, set bit inverts that terminal
// - six-bit virtual input enable, reset 0; bits 0-3 are general inputs one-four
// - virtual enable bit 4 is fast input a, bit 5 fast input b
// - general input one switch-on delay 0 to 50 s in ms, default 0
// - general input one switch-off delay 0 to 50 s, default 0
// - other five inputs each have own on and off delays up to 50 s
// - on a fault, input states captured into read-only snapshot, reset 0x0000
// - read-only live conditioned input state, reads 0x00 after reset
// - two relays, open collector, pulse-capable output selectable pulse or digital
// - each output decodes its own function code; codes may repeat
// - function code 0 keeps the output inactive
// - code 1 asserts while running with non-zero output frequency
// - codes 2 and 3 assert during forward or reverse running with frequency
// - code 4 asserts while jogging with frequency output
// - code 5 asserts whenever a drive fault is present
// - code 9 asserts only when output and reference frequency are zero
// - code 10 asserts when running frequency reaches upper limit
// - code 11 asserts when running frequency reached lower limit
// - code 12 ready: powers established and no protection acting
// - code 12 ready only once the drive is prepared to run
`timescale 1ns/10ps
`include "dio_cfg.svh"

module dio_top #(
	parameter int N_IN        = 6,
	parameter int N_OUT       = 4,
	parameter int TICK_CYCLES = `DIO_TICK_CYCLES
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic             clk_en,
	input  wire logic [N_IN-1:0]  terminal_pin,
	input  wire dio_pkg::dio_drive_s drive,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [15:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [15:0]           reg_rdata,
	output logic [N_IN-1:0]       cond_in,
	output dio_pkg::dio_wiring_e  wiring_mode,
	output logic                  fire_mode_trigger,
	output logic                  tension_pid_switch,
	output dio_pkg::dio_dout_s    dout,
	output logic                  pulse_mode_sel
);
	import dio_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);

	logic [N_IN-1:0]  pin_meta;
	logic [N_IN-1:0]  pin_sync;
	logic [5:0]       polarity;
	logic [9:0]       filter_ms;
	logic [5:0]       virt_en;
	logic [5:0]       virt_val;
	logic             pulse_mode;
	dio_func_t        out_func [N_OUT];
	logic [6:0]       in_func  [N_IN];
	logic [15:0]      on_delay [N_IN];
	logic [15:0]      off_delay[N_IN];
	logic [15:0]      fault_snap;
	logic [7:0]       live_state;
	logic             fault_q;
	logic [TW-1:0]    tick_cnt;
	logic             ms_tick;
	logic [N_IN-1:0]  raw_in;
	logic [15:0]      wr_delay;
	logic [9:0]       wr_filter;
	logic [N_OUT-1:0] next_dout;
	logic [15:0]      next_rdata;
	logic             next_fire;
	logic             next_tension;

	// pins are asynchronous to ref_clk; the first stage feeds only the second
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else if (clk_en) begin
			pin_meta <= terminal_pin;
			pin_sync <= pin_meta;
		end
	end

	// one millisecond time base shared by all terminals
	// free-running, so a filter or delay may stretch by up to one tick but is never short
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tick_cnt <= '0;
			ms_tick  <= 1'b0;
		end else if (clk_en) begin
			if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
				tick_cnt <= '0;
				ms_tick  <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt + TW'(1);
				ms_tick  <= 1'b0;
			end
		end
	end

	// virtual value replaces the pin where enabled, then polarity applies to either source
	always_comb begin
		for (int i = 0; i < N_IN; i++) begin
			raw_in[i] = (virt_en[i] ? virt_val[i] : pin_sync[i]) ^ polarity[i];
		end
	end

	for (genvar g = 0; g < N_IN; g++) begin : g_term
		dio_term #(
			.FW (10),
			.DW (16)
		) u_term (
			.ref_clk (ref_clk),
			.srst    (srst),
			.clk_en  (clk_en),
			.ms_tick (ms_tick),
			.raw     (raw_in[g]),
			.filt_ms (filter_ms),
			.on_ms   (on_delay[g]),
			.off_ms  (off_delay[g]),
			.cond    (cond_in[g])
		);
	end

	// out-of-range writes saturate rather than wrap, so a bad value never gives a short delay
	assign wr_delay  = (reg_wdata > `DIO_MAX_DELAY_MS) ? `DIO_MAX_DELAY_MS : reg_wdata;
	assign wr_filter = (reg_wdata > 16'(`DIO_MAX_FILTER_MS)) ? `DIO_MAX_FILTER_MS : reg_wdata[9:0];

	// input conditioning controls
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			polarity   <= `DIO_RST_POLARITY;
			filter_ms  <= `DIO_RST_FILTER_MS;
			virt_en    <= `DIO_RST_VIRT_EN;
			virt_val   <= 6'h00;
			wiring_mode <= DIO_TWO_WIRE_ONE;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				`DIO_ADDR_POLARITY: begin
					polarity <= reg_wdata[5:0];
				end
				`DIO_ADDR_FILTER: begin
					filter_ms <= wr_filter;
				end
				`DIO_ADDR_VIRT_EN: begin
					virt_en <= reg_wdata[5:0];
				end
				`DIO_ADDR_VIRT_VAL: begin
					virt_val <= reg_wdata[5:0];
				end
				`DIO_ADDR_WIRING: begin
					wiring_mode <= dio_wiring_e'(reg_wdata[1:0]);
				end
				default: begin
				end
			endcase
		end
	end

	// per-terminal switch-on and switch-off delays, two words per terminal
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < N_IN; i++) begin
				on_delay[i]  <= `DIO_RST_DELAY_MS;
				off_delay[i] <= `DIO_RST_DELAY_MS;
			end
		end else if (clk_en && reg_wr) begin
			for (int i = 0; i < N_IN; i++) begin
				if (reg_addr == `DIO_ADDR_DELAY0 + 8'(2 * i)) begin
					on_delay[i] <= wr_delay;
				end
				if (reg_addr == `DIO_ADDR_DELAY0 + 8'(2 * i + 1)) begin
					off_delay[i] <= wr_delay;
				end
			end
		end
	end

	// input function selections
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < N_IN; i++) begin
				in_func[i] <= 7'h00;
			end
		end else if (clk_en && reg_wr) begin
			for (int i = 0; i < N_IN; i++) begin
				if (reg_addr == `DIO_ADDR_IN_FUNC0 + 8'(i)) begin
					in_func[i] <= reg_wdata[6:0];
				end
			end
		end
	end

	// output function codes and pulse/digital selection
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pulse_mode <= 1'b0;
			for (int k = 0; k < N_OUT; k++) begin
				out_func[k] <= `DIO_OUT_NONE;
			end
		end else if (clk_en && reg_wr) begin
			if (reg_addr == `DIO_ADDR_PULSE_MODE) begin
				pulse_mode <= reg_wdata[0];
			end
			for (int k = 0; k < N_OUT; k++) begin
				if (reg_addr == `DIO_ADDR_OUT_FUNC0 + 8'(k)) begin
					out_func[k] <= reg_wdata[5:0];
				end
			end
		end
	end

	// codes other than 82 and 83, including reserved 84-95, drive nothing here
	always_comb begin
		next_fire    = 1'b0;
		next_tension = 1'b0;
		for (int i = 0; i < N_IN; i++) begin
			if (cond_in[i] && in_func[i] == `DIO_IN_FIRE_MODE) begin
				next_fire = 1'b1;
			end
			if (cond_in[i] && in_func[i] == `DIO_IN_TENSION_PID) begin
				next_tension = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fire_mode_trigger  <= 1'b0;
			tension_pid_switch <= 1'b0;
		end else if (clk_en) begin
			fire_mode_trigger  <= next_fire;
			tension_pid_switch <= next_tension;
		end
	end

	// each output decodes on its own, so one code may serve several outputs
	// codes above 12 fall to the default branch and stay inactive
	always_comb begin
		for (int k = 0; k < N_OUT; k++) begin
			case (out_func[k])
				`DIO_OUT_NONE: next_dout[k] = 1'b0;
				`DIO_OUT_RUNNING: next_dout[k] = drive.running && !drive.out_freq_zero;
				`DIO_OUT_FORWARD: next_dout[k] = drive.forward && !drive.out_freq_zero;
				`DIO_OUT_REVERSE: next_dout[k] = drive.reverse && !drive.out_freq_zero;
				`DIO_OUT_JOG: next_dout[k] = drive.jogging && !drive.out_freq_zero;
				`DIO_OUT_FAULT: next_dout[k] = drive.fault;
				`DIO_OUT_FREQ_LEVEL_ONE: next_dout[k] = drive.freq_level_detect_one;
				`DIO_OUT_FREQ_LEVEL_TWO: next_dout[k] = drive.freq_level_detect_two;
				`DIO_OUT_FREQ_REACHED: next_dout[k] = drive.freq_reached;
				`DIO_OUT_ZERO_SPEED: next_dout[k] = drive.out_freq_zero && drive.ref_freq_zero;
				`DIO_OUT_UPPER_LIMIT: next_dout[k] = drive.running && drive.at_upper_limit;
				`DIO_OUT_LOWER_LIMIT: next_dout[k] = drive.running && drive.at_lower_limit;
				`DIO_OUT_READY: next_dout[k] = drive.main_power_ok && drive.ctrl_power_ok
					&& !drive.protection_active && drive.ready_to_run;
				default: next_dout[k] = 1'b0;
			endcase
		end
	end

	// in pulse mode the pulse generator owns the pin, so the digital level is held low
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dout           <= '0;
			pulse_mode_sel <= 1'b0;
		end else if (clk_en) begin
			dout.relay_one            <= next_dout[0];
			dout.relay_two            <= next_dout[1];
			dout.open_collector       <= next_dout[2];
			dout.pulse_capable_output <= next_dout[3] && !pulse_mode;
			pulse_mode_sel            <= pulse_mode;
		end
	end

	// snapshot taken on the rising edge of the fault so it keeps the states that led to it
	// a fault already present at reset release is captured on the first enabled cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fault_q    <= 1'b0;
			fault_snap <= `DIO_RST_FAULT_SNAP;
			live_state <= `DIO_RST_LIVE_STATE;
		end else if (clk_en) begin
			fault_q    <= drive.fault;
			live_state <= 8'(cond_in);
			if (drive.fault && !fault_q) begin
				fault_snap <= 16'(cond_in);
			end
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = 16'h0000;
		case (reg_addr)
			`DIO_ADDR_POLARITY:   next_rdata = 16'(polarity);
			`DIO_ADDR_FILTER:     next_rdata = 16'(filter_ms);
			`DIO_ADDR_VIRT_EN:    next_rdata = 16'(virt_en);
			`DIO_ADDR_VIRT_VAL:   next_rdata = 16'(virt_val);
			`DIO_ADDR_WIRING:     next_rdata = 16'(wiring_mode);
			`DIO_ADDR_PULSE_MODE: next_rdata = 16'(pulse_mode);
			`DIO_ADDR_FAULT_SNAP: next_rdata = fault_snap;
			`DIO_ADDR_LIVE_STATE: next_rdata = 16'(live_state);
			default: begin
				for (int k = 0; k < N_OUT; k++) begin
					if (reg_addr == `DIO_ADDR_OUT_FUNC0 + 8'(k)) begin
						next_rdata = 16'(out_func[k]);
					end
				end
				for (int i = 0; i < N_IN; i++) begin
					if (reg_addr == `DIO_ADDR_IN_FUNC0 + 8'(i)) begin
						next_rdata = 16'(in_func[i]);
					end
					if (reg_addr == `DIO_ADDR_DELAY0 + 8'(2 * i)) begin
						next_rdata = on_delay[i];
					end
					if (reg_addr == `DIO_ADDR_DELAY0 + 8'(2 * i + 1)) begin
						next_rdata = off_delay[i];
					end
				end
			end
		endcase
	end

	// read data stands for exactly the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 16'h0000;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? next_rdata : 16'h0000;
		end
	end

endmodule // dio_top
